//--- logic/iscf_pkg.sv
`default_nettype none
package iscf_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] OFS_STAT    = 8'h18;
  localparam logic [7:0] OFS_CLEAR   = 8'h1C;
  localparam logic [7:0] OFS_RDATA   = 8'h24;
  localparam logic [7:0] OFS_TDATA   = 8'h28;
  localparam logic [7:0] OFS_CTRL    = 8'h40;
  localparam logic [7:0] OFS_COUNT   = 8'h44;
  localparam logic [7:0] OFS_IRQ_EN  = 8'h48;
  localparam logic [7:0] OFS_EVENTS  = 8'h4C;
  // ==========================================================
  // status bit positions
  localparam int B_TXE    = 0;
  localparam int B_TXREQ  = 1;
  localparam int B_RXF    = 2;
  localparam int B_ADDR   = 3;
  localparam int B_NACK   = 4;
  localparam int B_STOP   = 5;
  localparam int B_TDONE  = 6;
  localparam int B_RDONE  = 7;
  localparam int B_BUSF   = 8;
  localparam int B_ALERT  = 13;
  // ==========================================================
  // control bit positions
  localparam int C_ON     = 0;
  localparam int C_MASTER = 1;
  localparam int C_RELOAD = 2;
  localparam int C_ASTOP  = 3;
  localparam int C_NOSTR  = 4;
  localparam int C_START  = 5;
  localparam int C_STOPRQ = 6;
  localparam int C_IRQON  = 7;
  localparam int C_DMAON  = 8;
  // ==========================================================
  // masks, reset values and response codes
  localparam logic [31:0] CLEAR_MASK  = 32'h0000_3F38;
  localparam logic [31:0] STAT_RESET  = 32'h0000_0001;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // bus engine events, one-cycle pulses
  typedef struct packed {
    logic       count_done;
    logic       stop_seen;
    logic       nack;
    logic       addr_match;
    logic       rx_byte;
    logic [7:0] rx_data;
    logic       tx_ready;
    logic       tx_taken;
    logic [5:0] fault;
  } iscf_evt_type;

  typedef struct packed {
    logic        aw_done;
    logic        w_done;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [31:0] stat;
    logic [31:0] ctrl;
    logic [7:0]  byte_count;
    logic [31:0] irq_en;
    logic [7:0]  rx_data;
    logic [7:0]  tx_data;
    logic        tx_strobe;
    logic        start_pulse;
    logic        stop_pulse;
  } iscf_state_type;
endpackage : iscf_pkg
`default_nettype wire

//--- logic/iscf_flags.sv
// The AXI4-Lite slave port is this design's own decision.
`default_nettype none
module iscf_flags (
  // clock and reset
  input  wire logic                  clk_sys_i,
  input  wire logic                  srst_i,
  // axi4-lite slave
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  output logic [1:0]                 s_axi_bresp,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  input  wire logic [7:0]            s_axi_araddr,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  // bus engine events
  input  wire iscf_pkg::iscf_evt_type evt_i,
  // engine controls
  output logic [31:0]                ctrl_o,
  output logic [7:0]                 byte_count_o,
  output logic [7:0]                 tx_data_o,
  output logic                       tx_strobe_o,
  output logic                       start_pulse_o,
  output logic                       stop_pulse_o,
  output logic                       tx_dma_req_o,
  output logic                       irq_o
);
  iscf_pkg::iscf_state_type s_q;
  iscf_pkg::iscf_state_type s_d;

  // ==========================================================
  // address decode
  function automatic logic known(input logic [7:0] a);
    known = (a == iscf_pkg::OFS_STAT) || (a == iscf_pkg::OFS_CLEAR) ||
            (a == iscf_pkg::OFS_RDATA) || (a == iscf_pkg::OFS_TDATA) ||
            (a == iscf_pkg::OFS_CTRL) || (a == iscf_pkg::OFS_COUNT) ||
            (a == iscf_pkg::OFS_IRQ_EN) || (a == iscf_pkg::OFS_EVENTS);
  endfunction : known

  logic        wr_go;
  logic        rd_go;
  logic [7:0]  waddr;
  logic [31:0] wdata;
  logic [31:0] wmask;

  assign s_axi_awready = !s_q.aw_done && !s_q.bvalid;
  assign s_axi_wready  = !s_q.w_done && !s_q.bvalid;
  assign s_axi_arready = !s_q.rvalid;

  always_comb begin
    logic aw_now;
    logic w_now;
    aw_now = s_q.aw_done || (s_axi_awvalid && s_axi_awready);
    w_now  = s_q.w_done || (s_axi_wvalid && s_axi_wready);
    wr_go  = aw_now && w_now && !s_q.bvalid;
    waddr  = s_q.aw_done ? s_q.aw_addr : s_axi_awaddr;
    wdata  = s_q.w_done ? s_q.w_data : s_axi_wdata;
    wmask  = {{8{(s_q.w_done ? s_q.w_strb[3] : s_axi_wstrb[3])}},
              {8{(s_q.w_done ? s_q.w_strb[2] : s_axi_wstrb[2])}},
              {8{(s_q.w_done ? s_q.w_strb[1] : s_axi_wstrb[1])}},
              {8{(s_q.w_done ? s_q.w_strb[0] : s_axi_wstrb[0])}}};
    rd_go  = s_axi_arvalid && s_axi_arready;
  end

  // ==========================================================
  // next state
  always_comb begin
    logic [31:0] st;
    logic [31:0] cmask;
    logic [31:0] nctl;
    logic [7:0]  nbc;
    logic        slave;
    s_d   = s_q;
    st    = s_q.stat;
    cmask = 32'h0000_0000;
    nctl  = s_q.ctrl;
    nbc   = s_q.byte_count;
    slave = !s_q.ctrl[iscf_pkg::C_MASTER];
    s_d.tx_strobe   = 1'b0;
    s_d.start_pulse = 1'b0;
    s_d.stop_pulse  = 1'b0;
    // channel capture
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.aw_done = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.w_done = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    // software clears and writes first, hardware sets win after
    if (wr_go) begin
      s_d.aw_done = 1'b0;
      s_d.w_done  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = known(waddr) ? iscf_pkg::RESP_OKAY : iscf_pkg::RESP_SLVERR;
      case (waddr)
        iscf_pkg::OFS_CLEAR: begin
          cmask = wdata & wmask & iscf_pkg::CLEAR_MASK;
        end
        iscf_pkg::OFS_STAT: begin
          if (wmask[0] && wdata[iscf_pkg::B_TXE]) begin
            st[iscf_pkg::B_TXE] = 1'b1;
          end
          if (wmask[0] && wdata[iscf_pkg::B_TXREQ] && slave &&
              s_q.ctrl[iscf_pkg::C_NOSTR]) begin
            st[iscf_pkg::B_TXREQ] = 1'b1;
          end
        end
        iscf_pkg::OFS_TDATA: begin
          if (wmask[0]) begin
            s_d.tx_data           = wdata[7:0];
            s_d.tx_strobe         = 1'b1;
            st[iscf_pkg::B_TXE]   = 1'b0;
            st[iscf_pkg::B_TXREQ] = 1'b0;
          end
        end
        iscf_pkg::OFS_CTRL: begin
          nctl = (s_q.ctrl & ~wmask) | (wdata & wmask);
          if (nctl[iscf_pkg::C_START] || nctl[iscf_pkg::C_STOPRQ]) begin
            st[iscf_pkg::B_TDONE] = 1'b0;
          end
          s_d.start_pulse = nctl[iscf_pkg::C_START];
          s_d.stop_pulse  = nctl[iscf_pkg::C_STOPRQ];
          nctl[iscf_pkg::C_START]  = 1'b0;
          nctl[iscf_pkg::C_STOPRQ] = 1'b0;
        end
        iscf_pkg::OFS_COUNT: begin
          if (wmask[0]) begin
            nbc = wdata[7:0];
            if (wdata[7:0] != 8'h00) begin
              st[iscf_pkg::B_RDONE] = 1'b0;
            end
          end
        end
        iscf_pkg::OFS_IRQ_EN: begin
          s_d.irq_en = (s_q.irq_en & ~wmask) | (wdata & wmask);
        end
        default: begin
        end
      endcase
    end
    st = st & ~cmask;
    // register reads, RDATA read clears RXF
    if (rd_go) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = known(s_axi_araddr) ? iscf_pkg::RESP_OKAY : iscf_pkg::RESP_SLVERR;
      case (s_axi_araddr)
        iscf_pkg::OFS_STAT:   s_d.rdata = s_q.stat;
        iscf_pkg::OFS_RDATA: begin
          s_d.rdata             = {24'h000000, s_q.rx_data};
          st[iscf_pkg::B_RXF]   = 1'b0;
        end
        iscf_pkg::OFS_TDATA:  s_d.rdata = {24'h000000, s_q.tx_data};
        iscf_pkg::OFS_CTRL:   s_d.rdata = s_q.ctrl;
        iscf_pkg::OFS_COUNT:  s_d.rdata = {24'h000000, s_q.byte_count};
        iscf_pkg::OFS_IRQ_EN: s_d.rdata = s_q.irq_en;
        iscf_pkg::OFS_EVENTS: s_d.rdata = s_q.stat & s_q.irq_en;
        default:              s_d.rdata = 32'h0000_0000;
      endcase
    end
    // hardware sets
    if (evt_i.count_done && s_q.ctrl[iscf_pkg::C_RELOAD]) begin
      st[iscf_pkg::B_RDONE] = 1'b1;
    end
    if (evt_i.count_done && s_q.ctrl[iscf_pkg::C_MASTER] &&
        !s_q.ctrl[iscf_pkg::C_RELOAD] && !s_q.ctrl[iscf_pkg::C_ASTOP]) begin
      st[iscf_pkg::B_TDONE] = 1'b1;
    end
    if (evt_i.stop_seen) begin
      st[iscf_pkg::B_STOP] = 1'b1;
    end
    if (evt_i.nack) begin
      st[iscf_pkg::B_NACK] = 1'b1;
    end
    if (evt_i.addr_match && slave) begin
      st[iscf_pkg::B_ADDR] = 1'b1;
    end
    if (evt_i.rx_byte) begin
      s_d.rx_data         = evt_i.rx_data;
      st[iscf_pkg::B_RXF] = 1'b1;
    end
    if (evt_i.tx_ready) begin
      st[iscf_pkg::B_TXREQ] = 1'b1;
    end
    if (evt_i.tx_taken) begin
      st[iscf_pkg::B_TXE] = 1'b1;
    end
    st[iscf_pkg::B_ALERT:iscf_pkg::B_BUSF] = st[iscf_pkg::B_ALERT:iscf_pkg::B_BUSF] |
                                             evt_i.fault;
    if (!nctl[iscf_pkg::C_ON]) begin
      st = st & ~iscf_pkg::CLEAR_MASK;
    end
    st[31:14]      = 18'h00000;
    st[2]          = st[iscf_pkg::B_RXF];
    s_d.stat       = st;
    s_d.ctrl       = nctl;
    s_d.byte_count = nbc;
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      s_q        <= '0;
      s_q.stat   <= iscf_pkg::STAT_RESET;
      s_q.ctrl   <= iscf_pkg::CTRL_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;
  assign ctrl_o        = s_q.ctrl;
  assign byte_count_o  = s_q.byte_count;
  assign tx_data_o     = s_q.tx_data;
  assign tx_strobe_o   = s_q.tx_strobe;
  assign start_pulse_o = s_q.start_pulse;
  assign stop_pulse_o  = s_q.stop_pulse;
  assign tx_dma_req_o  = s_q.stat[iscf_pkg::B_TXREQ] && s_q.ctrl[iscf_pkg::C_DMAON];
  assign irq_o         = (|(s_q.stat & s_q.irq_en)) ||
                         (s_q.stat[iscf_pkg::B_TXREQ] && s_q.ctrl[iscf_pkg::C_IRQON]);
endmodule : iscf_flags
`default_nettype wire

//--- dv/iscf_engine_model.sv
`default_nettype none
module iscf_engine_model #(
  parameter int TAKE_DLY = 3
) (
  // clock, reset and requests
  input  wire logic                   clk_sys_i,
  input  wire logic                   srst_i,
  input  wire iscf_pkg::iscf_evt_type req_i,
  input  wire logic                   tx_strobe_i,
  // events toward the block
  output var iscf_pkg::iscf_evt_type  evt_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int                     cnt = 0;
  iscf_pkg::iscf_evt_type nxt;
  // ==========
  // one-cycle bus events, byte taken after a delay
  always_comb begin
    nxt          = req_i;
    nxt.tx_taken = req_i.tx_taken || (cnt == 1);
  end
  always @(posedge clk_sys_i) begin
    cnt <= srst_i ? 0 : tx_strobe_i ? TAKE_DLY : cnt > 0 ? cnt - 1 : 0;
    evt_o <= srst_i ? '0 : nxt;
  end
endmodule : iscf_engine_model
`default_nettype wire

//--- dv/iscf_flags_chk.sv
`default_nettype none
module iscf_flags_chk (
  // clock, reset and bus
  input wire logic                   clk_sys_i,
  input wire logic                   srst_i,
  input wire logic                   s_axi_awvalid,
  input wire logic                   s_axi_awready,
  input wire logic [7:0]             s_axi_awaddr,
  input wire logic                   s_axi_wvalid,
  input wire logic                   s_axi_wready,
  input wire logic [31:0]            s_axi_wdata,
  input wire logic                   s_axi_arvalid,
  input wire logic                   s_axi_arready,
  input wire logic [7:0]             s_axi_araddr,
  input wire logic [31:0]            s_axi_rdata,
  // engine side
  input wire iscf_pkg::iscf_evt_type evt_i,
  input wire logic [31:0]            ctrl_o,
  input wire logic                   tx_strobe_o,
  input wire logic                   start_pulse_o,
  input wire logic                   stop_pulse_o,
  input wire logic                   tx_dma_req_o,
  input wire logic                   irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        wr;
  logic [31:0] m_q;
  assign wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  // ==========
  // mask shadow and checks
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) m_q <= 32'h0;
    else if (wr && s_axi_awaddr == iscf_pkg::OFS_IRQ_EN) m_q <= s_axi_wdata;
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  chk_clear_zero: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr == iscf_pkg::OFS_CLEAR |=> s_axi_rdata == 32'h0) else $error("clear read");
  chk_dma_raise: assert property (ctrl_o[8] && evt_i.tx_ready && !wr |=> tx_dma_req_o)
    else $error("no dma request");
  chk_dma_drop: assert property (wr && s_axi_awaddr == iscf_pkg::OFS_TDATA
    && !evt_i.tx_ready |=> !tx_dma_req_o) else $error("dma request kept");
  chk_tx_strobe: assert property (wr && s_axi_awaddr == iscf_pkg::OFS_TDATA
    |-> ##[1:2] tx_strobe_o) else $error("no tx strobe");
  chk_start_pulse: assert property (wr && s_axi_awaddr == iscf_pkg::OFS_CTRL
    && s_axi_wdata[5] |-> ##[1:2] start_pulse_o) else $error("no start pulse");
  chk_stop_pulse: assert property (wr && s_axi_awaddr == iscf_pkg::OFS_CTRL
    && s_axi_wdata[6] |-> ##[1:2] stop_pulse_o) else $error("no stop pulse");
  chk_event_irq: assert property (ctrl_o[0] && !ctrl_o[1] && !wr
    && |({evt_i.fault, evt_i.stop_seen, evt_i.nack, evt_i.addr_match} & {m_q[13:8], m_q[5:3]})
    |=> irq_o) else $error("no irq after event");
  chk_rx_irq: assert property (evt_i.rx_byte && m_q[2] && !wr |=> irq_o)
    else $error("no irq after byte");
  chk_off_quiet: assert property ((!ctrl_o[0] && !ctrl_o[7]
    && (m_q & ~iscf_pkg::CLEAR_MASK) == 32'h0) [*2] |-> !irq_o) else $error("irq while off");
endmodule : iscf_flags_chk
bind iscf_flags iscf_flags_chk iscf_flags_chk_i (.clk_sys_i, .srst_i, .s_axi_awvalid,
  .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_arvalid,
  .s_axi_arready, .s_axi_araddr, .s_axi_rdata, .evt_i, .ctrl_o, .tx_strobe_o, .start_pulse_o,
  .stop_pulse_o, .tx_dma_req_o, .irq_o);
`default_nettype wire

//--- dv/iscf_flags_tb.sv
`default_nettype none
module iscf_flags_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                        clk = 1'b0, srst = 1'b1;
  logic                        awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [7:0]                  aa = 8'h00, ra = 8'h00, d;
  logic [31:0]                 wd = 32'h0, rdv, es, x;
  logic [1:0]                  rrs, brs;
  wire logic                   awr, wrd, bv, arr, rv, strb, dma, irq;
  wire logic [1:0]             rrp, brp;
  wire logic [7:0]             bc, txd;
  wire logic [31:0]            rdat, ctl;
  iscf_pkg::iscf_evt_type      req = '0, e;
  wire iscf_pkg::iscf_evt_type evt;
  int                          failures = 0, n_checks = 0, i, k;
  always #20 clk = ~clk;
  iscf_flags iscf_flags_i (.clk_sys_i(clk), .srst_i(srst), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_awaddr(aa), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_bresp(brp),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ra), .s_axi_rvalid(rv),
    .s_axi_rready(rry), .s_axi_rdata(rdat), .s_axi_rresp(rrp), .evt_i(evt), .ctrl_o(ctl),
    .byte_count_o(bc), .tx_data_o(txd), .tx_strobe_o(strb), .start_pulse_o(), .stop_pulse_o(),
    .tx_dma_req_o(dma), .irq_o(irq));
  iscf_engine_model #(.TAKE_DLY(40)) iscf_engine_model_i (.clk_sys_i(clk), .srst_i(srst),
    .req_i(req), .tx_strobe_i(strb), .evt_o(evt));
  // ==========
  // tasks
  task automatic cmp(input logic [31:0] g, input logic [31:0] xp);
    n_checks++;
    if (g !== xp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, xp);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    logic ta, tw, b;
    b = 1'b0;
    @(posedge clk);
    {awv, wv, bry} <= 3'b111;
    aa <= a;
    wd <= w;
    while (!b) begin
      @(negedge clk);
      {ta, tw, b, brs} = {awv && awr, wv && wrd, bv, brp};
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end
    bry <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] xp);
    logic ta, b;
    b = 1'b0;
    @(posedge clk);
    {arv, rry} <= 2'b11;
    ra <= a;
    while (!b) begin
      @(negedge clk);
      {ta, b, rdv, rrs} = {arv && arr, rv, rdat, rrp};
      @(posedge clk);
      if (ta) arv <= 1'b0;
    end
    rry <= 1'b0;
    cmp(rdv, xp);
  endtask : rd
  task automatic ev(input iscf_pkg::iscf_evt_type v);
    @(posedge clk);
    req <= v;
    @(posedge clk);
    req <= '0;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask : ev
  function automatic logic [31:0] flag_of(input int n);
    return n < 3 ? 32'h8 << n : 32'h100 << (n - 3);
  endfunction : flag_of
  task automatic tally_and_finish;
    if (failures == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(21));
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    rd(iscf_pkg::OFS_STAT, iscf_pkg::STAT_RESET);
    rd(iscf_pkg::OFS_CLEAR, 32'h0);
    wr(iscf_pkg::OFS_IRQ_EN, iscf_pkg::CLEAR_MASK | 32'h4);
    wr(iscf_pkg::OFS_CTRL, 32'h1);
    es = iscf_pkg::STAT_RESET;
    for (i = 0; i < 30; i++) begin
      k = $urandom_range(8, 0);
      e = '0;
      {e.fault, e.stop_seen, e.nack, e.addr_match} = 9'h1 << k;
      ev(e);
      es = es | flag_of(k);
      cmp({31'h0, irq}, 32'h1);
      rd(iscf_pkg::OFS_STAT, es);
      x = $urandom & iscf_pkg::CLEAR_MASK;
      wr(iscf_pkg::OFS_CLEAR, x);
      es = es & ~x;
      rd(iscf_pkg::OFS_STAT, es);
    end
    wr(iscf_pkg::OFS_CTRL, 32'h0);
    es = es & ~iscf_pkg::CLEAR_MASK;
    e = '0;
    e.stop_seen = 1'b1;
    ev(e);
    cmp({31'h0, irq}, 32'h0);
    rd(iscf_pkg::OFS_STAT, es);
    e = '0;
    d = 8'($urandom);
    {e.rx_byte, e.rx_data} = {1'b1, d};
    ev(e);
    cmp({31'h0, irq}, 32'h1);
    rd(iscf_pkg::OFS_STAT, es | 32'h4);
    rd(iscf_pkg::OFS_RDATA, {24'h0, d});
    rd(iscf_pkg::OFS_STAT, es);
    for (k = 0; k < 3; k++) begin
      wr(iscf_pkg::OFS_CTRL, k == 0 ? 32'h5 : 32'h3);
      e = '0;
      e.count_done = 1'b1;
      ev(e);
      x = k == 0 ? 32'h80 : 32'h40;
      rd(iscf_pkg::OFS_STAT, es | x);
      if (k == 0) wr(iscf_pkg::OFS_COUNT, 32'h0);
      rd(iscf_pkg::OFS_STAT, es | x);
      wr(k == 0 ? iscf_pkg::OFS_COUNT : iscf_pkg::OFS_CTRL, k == 0 ? 32'h5 : 32'h3 | 32'h10 << k);
      rd(iscf_pkg::OFS_STAT, es);
    end
    cmp(ctl, 32'h3);
    cmp({24'h0, bc}, 32'h5);
    wr(iscf_pkg::OFS_CTRL, 32'h111);
    wr(iscf_pkg::OFS_STAT, 32'h2);
    es = es | 32'h2;
    @(negedge clk);
    cmp({31'h0, dma}, 32'h1);
    wr(iscf_pkg::OFS_TDATA, {24'h0, d});
    cmp({24'h0, txd}, {24'h0, d});
    es = es & ~32'h3;
    rd(iscf_pkg::OFS_STAT, es);
    wr(iscf_pkg::OFS_STAT, 32'h1);
    es = es | 32'h1;
    rd(iscf_pkg::OFS_STAT, es);
    e = '0;
    e.tx_ready = 1'b1;
    ev(e);
    rd(iscf_pkg::OFS_STAT, es | 32'h2);
    wr(iscf_pkg::OFS_IRQ_EN, 32'h0);
    @(negedge clk);
    cmp({31'h0, irq}, 32'h0);
    wr(iscf_pkg::OFS_CTRL, 32'h191);
    @(negedge clk);
    cmp({31'h0, irq}, 32'h1);
    rd(8'h00, 32'h0);
    cmp({30'h0, rrs}, {30'h0, iscf_pkg::RESP_SLVERR});
    wr(8'h00, 32'hFFFF_FFFF);
    cmp({30'h0, brs}, {30'h0, iscf_pkg::RESP_SLVERR});
    wr(iscf_pkg::OFS_TDATA, {24'h0, d});
    es = es & ~32'h3;
    rd(iscf_pkg::OFS_STAT, es);
    repeat (45) @(posedge clk);
    es = es | 32'h1;
    rd(iscf_pkg::OFS_STAT, es);
    tally_and_finish();
  end
endmodule : iscf_flags_tb
`default_nettype wire
